// File: pkg/i2cs_pkg.sv
// constants, types and state records of the slave control port
// assumes one reference clock and one register-bank clock
package i2cs_pkg;

  // ****************************
  // bus figures
  // ****************************
  localparam logic [6:0] SLV_ADDR = 7'h1B;
  localparam logic [7:0] APPEND_SUB = 8'hFE;
  localparam int REF_CLK_KHZ = 20000;
  localparam int STD_KHZ = 100;
  localparam int FAST_KHZ = 400;
  localparam int FAST_BIT_CYC = REF_CLK_KHZ / FAST_KHZ;
  localparam int FILT_LEN = FAST_BIT_CYC / 16;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [4:0] FRAME_BYTES = 5'h04;
  localparam logic [4:0] FB_MAX = 5'h1F;

  // ****************************
  // subaddress classes
  // ****************************
  localparam logic [7:0] COEF_LO = 8'h20;
  localparam logic [7:0] BQ_LO = 8'h40;
  localparam logic [7:0] BQ_HI = 8'h7F;
  localparam logic [2:0] BQ_WORDS = 3'h5;
  localparam logic [2:0] COEF_WORDS = 3'h1;
  localparam logic [2:0] BYTE_MODE = 3'h0;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_SUB = 7'h04,
    ST_DATA = 7'h08,
    ST_ACK = 7'h10,
    ST_TX = 7'h20,
    ST_RACK = 7'h40
  } i2cs_state_t;

  typedef logic [4:0][31:0] i2cs_buf_t;

  // one committed register write; nwords 0 means a one-byte register in data[0][7:0]
  typedef struct packed {
    logic [7:0] sub;
    logic [2:0] nwords;
    i2cs_buf_t data;
  } i2cs_wr_t;

  typedef struct packed {
    logic [7:0] sub;
    logic [2:0] word;
  } i2cs_rd_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [FILT_LEN-1:0] scl_f;
    logic [FILT_LEN-1:0] sda_f;
    logic scl;
    logic sda;
    logic scl_p;
    logic sda_p;
    i2cs_state_t st;
    i2cs_state_t nst;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic wf;
    logic app;
    logic opn;
    logic nack;
    logic [7:0] sub;
    logic [2:0] nw;
    logic [4:0] bcnt;
    logic [4:0] fb;
    i2cs_buf_t dbuf;
    i2cs_wr_t wcmd;
    logic wtog;
    logic [7:0] rsub;
    logic [2:0] rw;
    logic [1:0] rb;
    i2cs_rd_t rreq;
    logic rtog;
    logic [2:0] ra;
    logic [31:0] rbuf;
    logic sda_oe_n;
    logic sda_o;
  } i2cs_core_t;

  typedef struct packed {
    logic [2:0] wq;
    logic [2:0] rq;
    logic wr_stb;
    i2cs_wr_t wr;
    logic rd_req;
    i2cs_rd_t rd;
    logic [31:0] rdat;
    logic atog;
  } i2cs_bank_t;

  function automatic logic [2:0] i2cs_words(input logic [7:0] s);
    if (s >= BQ_LO && s <= BQ_HI) begin
      return BQ_WORDS;
    end else if (s >= COEF_LO) begin
      return COEF_WORDS;
    end
    return BYTE_MODE;
  endfunction

endpackage

// File: design/i2cs_ctrl_slave.sv
// slave-only two-wire control port with register-bank access
// assumes external pullups; bank side answers rd_data_i combinationally
//
// Functional notes
// - works at 100k and 400k rates
// - slave only, never stretches the clock
// - answers address 0011011, bytes 0x36/0x37
// - bytes are eight bits, msb first, acknowledged
// - start and stop seen while clock high
// - acknowledge holds data low whole ack period
// - no limit on bytes per transfer
// - coefficients only in four-byte groups
// - reads stream bytes while master acknowledges
// - unused read bits return zero
// - short filter write is discarded
// - mixer coefficient needs one full word
// - sequential writes advance the subaddress
// - only the incomplete last set is dropped
// - write order address, sub, data, stop
// - every written data byte is acknowledged
// - four bytes then stop opens a filter register
// - append subaddress adds four bytes
// - full open register is committed
// - new subaddress flushes open register
// - wrong append byte count flushes
// - read direction flushes open register
// - read follows subaddress write and restart
module i2cs_ctrl_slave
  import i2cs_pkg::*;
(
  // clocks and reset
  input wire logic ref_clk_i,
  input wire logic bank_clk_i,
  input wire logic rst_n_i,
  // two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // register bank side, bank clock
  output logic wr_stb_o,
  output i2cs_wr_t wr_o,
  output logic rd_req_o,
  output i2cs_rd_t rd_o,
  input wire logic [31:0] rd_data_i
);

  i2cs_core_t c;
  i2cs_core_t next_c;
  i2cs_bank_t b;
  i2cs_bank_t next_b;

  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic load;
  logic [2:0] idx;
  logic [2:0] rnw;
  logic [7:0] rbyte;
  i2cs_buf_t nb;

  // ****************************
  // reference clock side
  // ****************************
  always_comb begin
    next_c = c;

    // ****************************
    // pin conditioning
    // ****************************
    // first flop of each synchroniser feeds only the second
    next_c.scl_s = {c.scl_s[0], scl_i};
    next_c.sda_s = {c.sda_s[0], sda_i};
    next_c.scl_f = {c.scl_f[FILT_LEN-2:0], c.scl_s[1]};
    next_c.sda_f = {c.sda_f[FILT_LEN-2:0], c.sda_s[1]};
    // glitch filter: level moves only when all samples agree
    if (&c.scl_f) begin
      next_c.scl = 1'b1;
    end else if (~|c.scl_f) begin
      next_c.scl = 1'b0;
    end
    if (&c.sda_f) begin
      next_c.sda = 1'b1;
    end else if (~|c.sda_f) begin
      next_c.sda = 1'b0;
    end
    next_c.scl_p = c.scl;
    next_c.sda_p = c.sda;
    rise = c.scl & ~c.scl_p;
    fall = ~c.scl & c.scl_p;
    start = c.scl & c.scl_p & c.sda_p & ~c.sda;
    stop = c.scl & c.scl_p & ~c.sda_p & c.sda;

    // ****************************
    // byte assembly and read byte pick
    // ****************************
    idx = c.bcnt[4:2];
    nb = c.dbuf;
    nb[idx] = {c.dbuf[idx][23:0], c.sh};
    rnw = i2cs_words(c.rsub);
    // one-byte registers expose only the low byte; the next byte read comes from the next subaddress
    if (rnw == BYTE_MODE) begin
      rbyte = c.rbuf[7:0];
    end else begin
      rbyte = c.rbuf[{~c.rb, 3'b000} +: 8];
    end
    load = fall && ((c.st == ST_ACK && c.nst == ST_TX) || (c.st == ST_RACK && !c.nack));

    // read answer from the bank clock, taken once its toggle settles
    // limitation: a bank slower than one byte time leaves rbuf stale
    next_c.ra = {c.ra[1:0], b.atog};
    if (c.ra[2] ^ c.ra[1]) begin
      next_c.rbuf = b.rdat;
    end

    // ****************************
    // bit sampling on the rising edge
    // ****************************
    if (rise) begin
      case (c.st)
        ST_ADDR, ST_SUB, ST_DATA: begin
          next_c.sh = {c.sh[6:0], c.sda};
          next_c.bitcnt = c.bitcnt + 4'h1;
        end
        ST_TX: begin
          next_c.bitcnt = c.bitcnt + 4'h1;
        end
        ST_RACK: begin
          next_c.nack = c.sda;
        end
        default: begin
        end
      endcase
    end

    // ****************************
    // byte sequencing on the falling edge
    // ****************************
    if (fall) begin
      case (c.st)
        ST_ADDR: begin
          if (c.bitcnt == BYTE_BITS) begin
            next_c.bitcnt = 4'h0;
            if (c.sh[7:1] == SLV_ADDR) begin
              next_c.sda_oe_n = 1'b0;
              next_c.st = ST_ACK;
              next_c.nst = c.sh[0] ? ST_TX : ST_SUB;
              if (c.sh[0]) begin
                // a read ends any pending incremental write
                if (c.opn) begin
                  next_c.opn = 1'b0;
                  next_c.bcnt = 5'h00;
                end
                next_c.rreq = '{sub: c.rsub, word: c.rw};
                next_c.rtog = ~c.rtog;
              end
            end else begin
              next_c.st = ST_IDLE;
            end
          end
        end
        ST_SUB: begin
          if (c.bitcnt == BYTE_BITS) begin
            next_c.bitcnt = 4'h0;
            next_c.sda_oe_n = 1'b0;
            next_c.st = ST_ACK;
            next_c.nst = ST_DATA;
            next_c.wf = 1'b1;
            next_c.fb = 5'h00;
            // append leaves the open register's sub and count as they are
            if (c.sh == APPEND_SUB) begin
              next_c.app = 1'b1;
            end else begin
              next_c.sub = c.sh;
              next_c.nw = i2cs_words(c.sh);
              next_c.opn = 1'b0;
              next_c.bcnt = 5'h00;
              next_c.rsub = c.sh;
              next_c.rw = 3'h0;
              next_c.rb = 2'h0;
              next_c.rreq = '{sub: c.sh, word: 3'h0};
              next_c.rtog = ~c.rtog;
            end
          end
        end
        ST_DATA: begin
          if (c.bitcnt == BYTE_BITS) begin
            next_c.bitcnt = 4'h0;
            next_c.sda_oe_n = 1'b0;
            next_c.st = ST_ACK;
            next_c.nst = ST_DATA;
            if (c.fb != FB_MAX) begin
              next_c.fb = c.fb + 5'h01;
            end
            if (c.app) begin
              // bytes past the fourth are dropped and flush at the frame end
              if (c.opn && c.fb < FRAME_BYTES) begin
                next_c.dbuf = nb;
                next_c.bcnt = c.bcnt + 5'h01;
              end
            end else if (c.nw == BYTE_MODE) begin
              next_c.wcmd.sub = c.sub;
              next_c.wcmd.nwords = BYTE_MODE;
              next_c.wcmd.data = '0;
              next_c.wcmd.data[0][7:0] = c.sh;
              next_c.wtog = ~c.wtog;
              next_c.sub = c.sub + 8'h01;
              next_c.nw = i2cs_words(c.sub + 8'h01);
            end else begin
              next_c.dbuf = nb;
              next_c.bcnt = c.bcnt + 5'h01;
              if (c.bcnt + 5'h01 == {c.nw, 2'b00}) begin
                next_c.wcmd.sub = c.sub;
                next_c.wcmd.nwords = c.nw;
                next_c.wcmd.data = nb;
                next_c.wtog = ~c.wtog;
                next_c.bcnt = 5'h00;
                next_c.sub = c.sub + 8'h01;
                next_c.nw = i2cs_words(c.sub + 8'h01);
              end
            end
          end
        end
        ST_ACK: begin
          next_c.sda_oe_n = 1'b1;
          next_c.st = c.nst;
        end
        ST_TX: begin
          if (c.bitcnt == BYTE_BITS) begin
            next_c.sda_oe_n = 1'b1;
            next_c.st = ST_RACK;
          end else begin
            next_c.tx = {c.tx[6:0], 1'b0};
            next_c.sda_oe_n = c.tx[6];
          end
        end
        ST_RACK: begin
          if (c.nack) begin
            next_c.st = ST_IDLE;
          end
        end
        default: begin
          next_c.st = ST_IDLE;
        end
      endcase
    end

    // ****************************
    // read byte load
    // ****************************
    // next read byte goes out on the falling edge; after a word's last byte the next word is fetched now
    if (load) begin
      next_c.tx = rbyte;
      next_c.sda_oe_n = rbyte[7];
      next_c.st = ST_TX;
      next_c.bitcnt = 4'h0;
      if (rnw == BYTE_MODE) begin
        next_c.rsub = c.rsub + 8'h01;
        next_c.rtog = ~c.rtog;
      end else if (c.rb == 2'h3) begin
        next_c.rb = 2'h0;
        next_c.rtog = ~c.rtog;
        if (c.rw == rnw - 3'h1) begin
          next_c.rw = 3'h0;
          next_c.rsub = c.rsub + 8'h01;
        end else begin
          next_c.rw = c.rw + 3'h1;
        end
      end else begin
        next_c.rb = c.rb + 2'h1;
      end
      next_c.rreq = '{sub: next_c.rsub, word: next_c.rw};
    end

    // ****************************
    // frame end
    // ****************************
    // frame end: stop or repeated start settles any partial data
    if (start || stop) begin
      if (c.wf && c.app) begin
        if (c.opn && c.fb == FRAME_BYTES) begin
          if (c.bcnt == {c.nw, 2'b00}) begin
            next_c.wcmd.sub = c.sub;
            next_c.wcmd.nwords = c.nw;
            next_c.wcmd.data = c.dbuf;
            next_c.wtog = ~c.wtog;
            next_c.opn = 1'b0;
            next_c.bcnt = 5'h00;
          end
        end else begin
          next_c.opn = 1'b0;
          next_c.bcnt = 5'h00;
        end
      end else if (c.wf && c.bcnt != 5'h00) begin
        // exactly four bytes to a long register leave it open for appends
        if (c.fb == FRAME_BYTES && c.bcnt == FRAME_BYTES && c.nw > COEF_WORDS) begin
          next_c.opn = 1'b1;
        end else begin
          next_c.bcnt = 5'h00;
        end
      end
      next_c.wf = 1'b0;
      next_c.app = 1'b0;
      next_c.sda_oe_n = 1'b1;
      next_c.bitcnt = 4'h0;
      next_c.st = start ? ST_ADDR : ST_IDLE;
    end
    // the data line is only ever pulled low, never driven high
    next_c.sda_o = 1'b0;
  end

  // scl is an input only: the port cannot hold the clock low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c <= '0;
      c.scl_s <= 2'h3;
      c.sda_s <= 2'h3;
      c.scl_f <= '1;
      c.sda_f <= '1;
      c.scl <= 1'b1;
      c.sda <= 1'b1;
      c.scl_p <= 1'b1;
      c.sda_p <= 1'b1;
      c.st <= ST_IDLE;
      c.nst <= ST_IDLE;
      c.nack <= 1'b1;
      c.sda_oe_n <= 1'b1;
    end else begin
      c <= next_c;
    end
  end

  // ****************************
  // bank clock side
  // ****************************
  // write words stay still for a whole byte time and read requests for at least one bit time, so a toggle carries them safely
  always_comb begin
    next_b = b;
    next_b.wq = {b.wq[1:0], c.wtog};
    next_b.rq = {b.rq[1:0], c.rtog};
    next_b.wr_stb = b.wq[2] ^ b.wq[1];
    if (b.wq[2] ^ b.wq[1]) begin
      next_b.wr = c.wcmd;
    end
    next_b.rd_req = b.rq[2] ^ b.rq[1];
    if (b.rq[2] ^ b.rq[1]) begin
      next_b.rd = c.rreq;
    end
    // bank answers within the request cycle; there is no wait state
    if (b.rd_req) begin
      next_b.rdat = rd_data_i;
      next_b.atog = ~b.atog;
    end
  end

  always_ff @(posedge bank_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      b <= '0;
    end else begin
      b <= next_b;
    end
  end

  // ****************************
  // outputs
  // ****************************
  assign sda_o = c.sda_o;
  assign sda_oe_n_o = c.sda_oe_n;
  assign wr_stb_o = b.wr_stb;
  assign wr_o = b.wr;
  assign rd_req_o = b.rd_req;
  assign rd_o = b.rd;

endmodule // i2cs_ctrl_slave

// File: tb/i2cs_ctrl_slave_chk.sv
// checker on the slave port pins and bank strobes
// assumes scl_i carries the wired bus level
module i2cs_ctrl_slave_chk
  import i2cs_pkg::*;
(
  // clocks and reset
  input logic ref_clk_i,
  input logic bank_clk_i,
  input logic rst_n_i,
  // pins
  input logic scl_i,
  input logic sda_o,
  input logic sda_oe_n_o,
  // bank side
  input logic wr_stb_o,
  input i2cs_wr_t wr_o,
  input logic rd_req_o,
  input i2cs_rd_t rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // pin domain
  // ****
  chk_drain_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !sda_o) else $error("data pin driven high");
  chk_edge_scl_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(sda_oe_n_o) |-> !scl_i) else $error("data moved with clock high");
  chk_ack_whole: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(sda_oe_n_o) |-> !sda_oe_n_o [*8]) else $error("low pull too short");
  // ****
  // bank domain
  // ****
  chk_wr_pulse: assert property (@(posedge bank_clk_i) disable iff (!rst_n_i)
    wr_stb_o |=> !wr_stb_o) else $error("write strobe too long");
  chk_rd_pulse: assert property (@(posedge bank_clk_i) disable iff (!rst_n_i)
    rd_req_o |=> !rd_req_o) else $error("read request too long");
  chk_wr_held: assert property (@(posedge bank_clk_i) disable iff (!rst_n_i)
    $changed(wr_o) |-> wr_stb_o) else $error("write record moved alone");
  chk_rd_held: assert property (@(posedge bank_clk_i) disable iff (!rst_n_i)
    $changed(rd_o) |-> rd_req_o) else $error("read record moved alone");
  chk_wr_shape: assert property (@(posedge bank_clk_i) disable iff (!rst_n_i)
    wr_stb_o |-> wr_o.sub != APPEND_SUB && wr_o.nwords inside {3'h0, 3'h1, 3'h5})
    else $error("bad write record");
  cov_write: cover property (@(posedge bank_clk_i) wr_stb_o);
  cov_read: cover property (@(posedge bank_clk_i) rd_req_o);
  cov_ack: cover property (@(posedge ref_clk_i) $fell(sda_oe_n_o));
endmodule // i2cs_ctrl_slave_chk

bind i2cs_ctrl_slave i2cs_ctrl_slave_chk chk_i (.ref_clk_i(ref_clk_i),
  .bank_clk_i(bank_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .wr_stb_o(wr_stb_o), .wr_o(wr_o), .rd_req_o(rd_req_o),
  .rd_o(rd_o));

// File: tb/i2cs_bus_master.sv
// master model for the two-wire control port
// assumes the bench ands its lines with the slave pull onto pulled-up wires
module i2cs_bus_master (
  // pacing clock
  input logic clk_i,
  // wire levels
  input logic sda_i,
  output logic scl_o = 1'b1,
  output logic sda_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  // quarter bit in clocks; 13 keeps a fast bit at 52
  int q = 13;
  task automatic step(input logic c, input logic d);
    scl_o = c;
    sda_o = d;
    repeat (q) @(negedge clk_i);
  endtask
  // also a repeated start when entered with the clock low
  task automatic start();
    step(scl_o, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic bit_io(input logic b, output logic r);
    step(1'b0, b);
    step(1'b1, b);
    r = sda_i;
    step(1'b1, b);
    step(1'b0, b);
  endtask
  // a is the acknowledge level, low when taken
  task automatic put(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(b[i], a);
    bit_io(1'b1, a);
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // i2cs_bus_master

// File: tb/i2c_control_slave_append_test.sv
// bench for the slave control port: master model on the wires, bank answered here
// assumes the checker is bound to the design
module i2c_control_slave_append_test;
  timeunit 1ns;
  timeprecision 1ns;
  import i2cs_pkg::*;
  logic ref_clk_i = 1'b0;
  logic bank_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic m_scl, m_sda, sda_o, sda_oe_n_o, wr_stb_o, rd_req_o, ack;
  logic [7:0] rb;
  logic [31:0] rd_data_i;
  i2cs_wr_t wr_o;
  i2cs_rd_t rd_o;
  i2cs_wr_t wq[$];
  int error_cnt = 0;
  int n_tests = 0;
  // pulled-up wire, either party may pull low
  wire logic sda = m_sda & (sda_oe_n_o | sda_o);
  // bank answer; one-byte registers keep upper bits zero
  assign rd_data_i = (rd_o.sub < 8'h20) ? {24'h0, rd_o.sub ^ 8'h5A}
                                        : {rd_o.sub, 5'h0, rd_o.word, 16'hA5C3};
  initial forever #25 ref_clk_i = ~ref_clk_i;
  initial begin
    #7;
    forever #32 bank_clk_i = ~bank_clk_i;
  end
  // sampled mid-cycle, away from the edge that launches the strobe
  always @(negedge bank_clk_i) if (wr_stb_o === 1'b1) wq.push_back(wr_o);
  i2cs_ctrl_slave dut (.ref_clk_i(ref_clk_i), .bank_clk_i(bank_clk_i), .rst_n_i(rst_n_i),
    .scl_i(m_scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .wr_stb_o(wr_stb_o), .wr_o(wr_o), .rd_req_o(rd_req_o), .rd_o(rd_o),
    .rd_data_i(rd_data_i));
  i2cs_bus_master mst (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(m_scl), .sda_o(m_sda));
  // ****
  // helpers
  // ****
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wframe(input logic [7:0] sub, input logic [7:0] d[$]);
    mst.start();
    mst.put(8'h36, ack);
    check(ack, 1'b0);
    mst.put(sub, ack);
    check(ack, 1'b0);
    foreach (d[i]) begin
      mst.put(d[i], ack);
      check(ack, 1'b0);
    end
    mst.stop();
    // crossing to the bank clock takes a few bank cycles
    repeat (20) @(negedge bank_clk_i);
  endtask
  function automatic logic [31:0] wd(input int k);
    return {8'(4 * k), 8'(4 * k + 1), 8'(4 * k + 2), 8'(4 * k + 3)};
  endfunction
  task automatic app(input logic [7:0] sub, input int k);
    logic [31:0] w;
    w = wd(k);
    wframe(sub, '{w[31:24], w[23:16], w[15:8], w[7:0]});
  endtask
  task automatic take(input logic [7:0] sub, input logic [2:0] nw, input i2cs_buf_t d);
    i2cs_wr_t e;
    e = '{sub, nw, d};
    check(32'(wq.size() > 0), 32'h1);
    if (wq.size() > 0) check(wq.pop_front(), e);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_byte_seq();
    wframe(8'h03, '{8'hA5, 8'h3C});
    take(8'h03, 3'h0, 160'hA5);
    take(8'h04, 3'h0, 160'h3C);
    mst.start();
    mst.put(8'h38, ack);
    mst.stop();
    check(ack, 1'b1);
    check(32'(wq.size()), 32'h0);
  endtask
  task automatic t_word();
    wframe(8'h20, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h99, 8'hAA});
    take(8'h20, 3'h1, 160'h11223344);
    take(8'h21, 3'h1, 160'h55667788);
    wframe(8'h42, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
    check(32'(wq.size()), 32'h0);
  endtask
  task automatic t_open();
    i2cs_buf_t e;
    for (int k = 0; k < 5; k++) begin
      app(k == 0 ? 8'h40 : APPEND_SUB, k);
      e[k] = wd(k);
    end
    take(8'h40, 3'h5, e);
    check(32'(wq.size()), 32'h0);
  endtask
  task automatic t_flush();
    for (int kind = 0; kind < 3; kind++) begin
      app(8'h41, 0);
      if (kind == 0) begin
        wframe(8'h05, '{8'h77});
        take(8'h05, 3'h0, 160'h77);
      end else if (kind == 1) begin
        wframe(APPEND_SUB, '{8'h01, 8'h02, 8'h03});
      end else begin
        mst.start();
        mst.put(8'h37, ack);
        mst.get(1'b1, rb);
        mst.stop();
        check(ack, 1'b0);
      end
      for (int k = 1; k < 5; k++) app(APPEND_SUB, k);
      check(32'(wq.size()), 32'h0);
    end
  endtask
  task automatic t_read();
    // standard rate: quarter bit of 50 clocks
    mst.q = 50;
    mst.start();
    mst.put(8'h36, ack);
    mst.put(8'h1F, ack);
    mst.start();
    mst.put(8'h37, ack);
    check(ack, 1'b0);
    mst.get(1'b0, rb);
    check(rb, 8'h1F ^ 8'h5A);
    mst.get(1'b0, rb);
    check(rb, 8'h20);
    mst.get(1'b1, rb);
    check(rb, 8'h00);
    mst.stop();
    check(sda_oe_n_o, 1'b1);
    mst.q = 13;
  endtask
  initial begin
    repeat (12) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (20) @(negedge ref_clk_i);
    t_byte_seq();
    t_word();
    t_open();
    t_flush();
    t_read();
    test_done();
  end
  initial begin
    repeat (98000) @(posedge ref_clk_i);
    error_cnt++;
    test_done();
  end
endmodule // i2c_control_slave_append_test
